// ---- rtl/regulator_control_registers.sv ----
// APB register bank for setpoints and control of two bucks and two linear regulators
module regulator_control_registers (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic voltageSelect,
    input wire logic [3:0] powerGood,
    input wire logic [3:0] regulatorFault,
    output logic [5:0] buck3Code,
    output logic [5:0] buck4Code,
    output logic [5:0] linear5Code,
    output logic [5:0] linear6Code,
    output logic [3:0] regulatorEnable,
    output logic [1:0] phaseInvert,
    output logic [1:0] dischargeEnable,
    output logic irq
);
    // Whole state of the bank in one record
    typedef struct packed {
        logic [5:0] b3Primary;
        logic [5:0] b3Secondary;
        logic [5:0] b4Primary;
        logic [5:0] b4Secondary;
        logic [5:0] l5Setpoint;
        logic [5:0] l6Setpoint;
        logic [3:0] regOn;
        logic [3:0] optionBit;
        logic [3:0] faultEn;
        logic [3:0] irqMask;
        logic [3:0] enableOut;
        logic [1:0] phaseOut;
        logic [1:0] dischargeOut;
        logic irqOut;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } bank_state_t;

    bank_state_t stateReg;
    bank_state_t stateNext;
    logic [3:0] faultStatus;
    logic [3:0] faultEvents;
    logic [3:0] clearBits;
    logic accessDone;
    logic writeDone;
    logic [7:0] writeIdx;

    // Word index of a byte address
    function automatic logic [7:0] regIndex(input logic [11:0] addr);
        return addr[9:2];
    endfunction : regIndex

    // True when the index names a register of the bank
    function automatic logic isMapped(input logic [7:0] idx);
        case (idx)
            regulator_control_pkg::BUCK3_PRIMARY_SETPOINT_IDX,
            regulator_control_pkg::BUCK3_SECONDARY_SETPOINT_IDX,
            regulator_control_pkg::BUCK3_CONTROL_IDX,
            regulator_control_pkg::BUCK4_PRIMARY_SETPOINT_IDX,
            regulator_control_pkg::BUCK4_SECONDARY_SETPOINT_IDX,
            regulator_control_pkg::BUCK4_CONTROL_IDX,
            regulator_control_pkg::LINEAR5_SETPOINT_IDX,
            regulator_control_pkg::LINEAR5_CONTROL_IDX,
            regulator_control_pkg::LINEAR6_SETPOINT_IDX,
            regulator_control_pkg::LINEAR6_CONTROL_IDX,
            regulator_control_pkg::FAULT_STATUS_IDX,
            regulator_control_pkg::FAULT_MASK_IDX: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction : isMapped

    // Control byte of one regulator; reserved bits 6:3 are zero
    function automatic logic [7:0] controlByte(input bank_state_t s, input logic [3:0] pg,
                                               input int r);
        return {s.regOn[r], 4'h0, s.optionBit[r], s.faultEn[r], pg[r]};
    endfunction : controlByte

    // Setpoint byte; bits 7:6 read as zero
    function automatic logic [7:0] setpointByte(input logic [5:0] code);
        return {2'h0, code};
    endfunction : setpointByte

    // Read value of a register, zero-extended onto the 32-bit bus
    function automatic logic [31:0] readWord(input bank_state_t s, input logic [7:0] idx,
                                             input logic [3:0] pg, input logic [3:0] st);
        logic [7:0] b;
        b = 8'h00;
        case (idx)
            regulator_control_pkg::BUCK3_PRIMARY_SETPOINT_IDX: b = setpointByte(s.b3Primary);
            regulator_control_pkg::BUCK3_SECONDARY_SETPOINT_IDX: b = setpointByte(s.b3Secondary);
            regulator_control_pkg::BUCK3_CONTROL_IDX: begin
                b = controlByte(s, pg, regulator_control_pkg::BUCK3);
            end
            regulator_control_pkg::BUCK4_PRIMARY_SETPOINT_IDX: b = setpointByte(s.b4Primary);
            regulator_control_pkg::BUCK4_SECONDARY_SETPOINT_IDX: b = setpointByte(s.b4Secondary);
            regulator_control_pkg::BUCK4_CONTROL_IDX: begin
                b = controlByte(s, pg, regulator_control_pkg::BUCK4);
            end
            regulator_control_pkg::LINEAR5_SETPOINT_IDX: b = setpointByte(s.l5Setpoint);
            regulator_control_pkg::LINEAR5_CONTROL_IDX: begin
                b = controlByte(s, pg, regulator_control_pkg::LINEAR5);
            end
            regulator_control_pkg::LINEAR6_SETPOINT_IDX: b = setpointByte(s.l6Setpoint);
            regulator_control_pkg::LINEAR6_CONTROL_IDX: begin
                b = controlByte(s, pg, regulator_control_pkg::LINEAR6);
            end
            regulator_control_pkg::FAULT_STATUS_IDX: b = {4'h0, st};
            regulator_control_pkg::FAULT_MASK_IDX: b = {4'h0, s.irqMask};
            default: b = 8'h00;
        endcase
        return {24'h00_0000, b};
    endfunction : readWord

    // Bus handshake terms; a write lands only on the completing edge
    assign accessDone = psel && penable && stateReg.pready;
    assign writeDone = accessDone && pwrite && pstrb[0] && !stateReg.pslverr;
    assign writeIdx = regIndex(paddr);

    // Faults only count while their enable is set
    assign faultEvents = regulatorFault & stateReg.faultEn;
    assign clearBits = (writeDone && writeIdx == regulator_control_pkg::FAULT_STATUS_IDX) ?
                       pwdata[3:0] : 4'h0;

    // Next state: bus answer, register writes and derived pin drives
    always_comb begin
        stateNext = stateReg;
        // Answer with no wait state: pready rises in the first access cycle
        stateNext.pready = psel && !penable;
        if (psel && !penable) begin
            stateNext.pslverr = !isMapped(regIndex(paddr));
            stateNext.prdata = pwrite ? 32'h0000_0000 :
                               readWord(stateReg, regIndex(paddr), powerGood, faultStatus);
        end else begin
            stateNext.pslverr = 1'b0;
            stateNext.prdata = 32'h0000_0000;
        end
        // Only the low byte lane carries data; upper bits of pwdata are dropped
        if (writeDone) begin
            case (writeIdx)
                regulator_control_pkg::BUCK3_PRIMARY_SETPOINT_IDX: begin
                    stateNext.b3Primary = pwdata[5:0];
                end
                regulator_control_pkg::BUCK3_SECONDARY_SETPOINT_IDX: begin
                    stateNext.b3Secondary = pwdata[5:0];
                end
                regulator_control_pkg::BUCK4_PRIMARY_SETPOINT_IDX: begin
                    stateNext.b4Primary = pwdata[5:0];
                end
                regulator_control_pkg::BUCK4_SECONDARY_SETPOINT_IDX: begin
                    stateNext.b4Secondary = pwdata[5:0];
                end
                regulator_control_pkg::LINEAR5_SETPOINT_IDX: begin
                    stateNext.l5Setpoint = pwdata[5:0];
                end
                regulator_control_pkg::LINEAR6_SETPOINT_IDX: begin
                    stateNext.l6Setpoint = pwdata[5:0];
                end
                regulator_control_pkg::BUCK3_CONTROL_IDX,
                regulator_control_pkg::BUCK4_CONTROL_IDX,
                regulator_control_pkg::LINEAR5_CONTROL_IDX,
                regulator_control_pkg::LINEAR6_CONTROL_IDX: begin
                    // A full index compare against ctrlIdx picks the regulator: 32/42 bucks vs 51/59 linears
                    for (int r = 0; r < 4; r++) begin
                        if (writeIdx == ctrlIdx(r)) begin
                            stateNext.regOn[r] = pwdata[regulator_control_pkg::ON_BIT];
                            stateNext.optionBit[r] = pwdata[regulator_control_pkg::OPTION_BIT];
                            stateNext.faultEn[r] = pwdata[regulator_control_pkg::FAULT_EN_BIT];
                        end
                    end
                end
                regulator_control_pkg::FAULT_MASK_IDX: begin
                    stateNext.irqMask = pwdata[3:0];
                end
                default: begin
                    stateNext.irqMask = stateReg.irqMask;
                end
            endcase
        end
        // Pin drives follow the stored bits one edge later
        stateNext.enableOut = stateReg.regOn;
        stateNext.phaseOut = stateReg.optionBit[1:0];
        // Discharge only when switched off, never while running
        stateNext.dischargeOut = stateReg.optionBit[3:2] & ~stateReg.regOn[3:2];
        stateNext.irqOut = |(faultStatus & stateReg.irqMask);
    end

    // Control register index of regulator r
    function automatic logic [7:0] ctrlIdx(input int r);
        case (r)
            0: return regulator_control_pkg::BUCK3_CONTROL_IDX;
            1: return regulator_control_pkg::BUCK4_CONTROL_IDX;
            2: return regulator_control_pkg::LINEAR5_CONTROL_IDX;
            default: return regulator_control_pkg::LINEAR6_CONTROL_IDX;
        endcase
    endfunction : ctrlIdx

    // True when the index names a control byte; the other bytes keep 7:6 reserved instead
    function automatic logic isControl(input logic [7:0] idx);
        return idx == ctrlIdx(0) || idx == ctrlIdx(1) || idx == ctrlIdx(2) || idx == ctrlIdx(3);
    endfunction : isControl

    // State register with synchronous reset
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            stateReg <= '{
                b3Primary: regulator_control_pkg::SETPOINT_RESET,
                b3Secondary: regulator_control_pkg::SETPOINT_RESET,
                b4Primary: regulator_control_pkg::SETPOINT_RESET,
                b4Secondary: regulator_control_pkg::SETPOINT_RESET,
                l5Setpoint: regulator_control_pkg::SETPOINT_RESET,
                l6Setpoint: regulator_control_pkg::SETPOINT_RESET,
                regOn: regulator_control_pkg::FLAGS_RESET,
                optionBit: regulator_control_pkg::FLAGS_RESET,
                faultEn: regulator_control_pkg::FLAGS_RESET,
                irqMask: regulator_control_pkg::FLAGS_RESET,
                enableOut: regulator_control_pkg::FLAGS_RESET,
                phaseOut: 2'h0,
                dischargeOut: 2'h0,
                irqOut: 1'b0,
                pready: 1'b0,
                pslverr: 1'b0,
                prdata: regulator_control_pkg::RDATA_RESET
            };
        end else begin
            stateReg <= stateNext;
        end
    end

    // Voltage code of the two dual-setpoint bucks
    setpoint_select buck3Select (
        .clk(clk),
        .reset_n(reset_n),
        .selectHigh(voltageSelect),
        .primaryCode(stateReg.b3Primary),
        .secondaryCode(stateReg.b3Secondary),
        .codeOut(buck3Code)
    );

    setpoint_select buck4Select (
        .clk(clk),
        .reset_n(reset_n),
        .selectHigh(voltageSelect),
        .primaryCode(stateReg.b4Primary),
        .secondaryCode(stateReg.b4Secondary),
        .codeOut(buck4Code)
    );

    // Sticky fault flags behind the per-regulator fault enable
    fault_latch faults (
        .clk(clk),
        .reset_n(reset_n),
        .eventIn(faultEvents),
        .clearBits(clearBits),
        .statusOut(faultStatus)
    );

    // Outputs straight from flip-flops
    assign prdata = stateReg.prdata;
    assign pready = stateReg.pready;
    assign pslverr = stateReg.pslverr;
    assign linear5Code = stateReg.l5Setpoint;
    assign linear6Code = stateReg.l6Setpoint;
    assign regulatorEnable = stateReg.enableOut;
    assign phaseInvert = stateReg.phaseOut;
    assign dischargeEnable = stateReg.dischargeOut;
    assign irq = stateReg.irqOut;

    // Checks on the bank's own behaviour
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    chk_select_high: assert property (
        voltageSelect |=> buck4Code == $past(stateReg.b4Secondary))
        else $error("buck4 code not secondary while select high");

    chk_select_low: assert property (
        !voltageSelect |=> buck3Code == $past(stateReg.b3Primary))
        else $error("buck3 code not primary while select low");

    chk_enable_write: assert property (
        writeDone && writeIdx == regulator_control_pkg::BUCK4_CONTROL_IDX
        |=> ##1 regulatorEnable[1] == $past(pwdata[7], 2))
        else $error("buck4 enable pin does not follow written bit");

    chk_phase_pin: assert property (
        ##1 phaseInvert == $past(stateReg.optionBit[1:0]))
        else $error("phase pins do not follow control bits");

    chk_fault_gated: assert property (
        !stateReg.faultEn[2] && !faultStatus[2] |=> !faultStatus[2])
        else $error("disabled fault raised status");

    chk_fault_sets: assert property (
        regulatorFault[0] && stateReg.faultEn[0] |=> faultStatus[0])
        else $error("enabled fault did not set status");

    chk_pgood_read: assert property (
        psel && !penable && !pwrite &&
        regIndex(paddr) == regulator_control_pkg::LINEAR5_CONTROL_IDX
        |=> pready && prdata[0] == $past(powerGood[2]))
        else $error("power-good bit read wrong");

    chk_discharge_off: assert property (
        stateReg.regOn[3] ##1 stateReg.regOn[3] |-> !dischargeEnable[1])
        else $error("discharge active while regulator on");

    chk_single_code: assert property (
        writeDone && writeIdx == regulator_control_pkg::LINEAR6_SETPOINT_IDX
        |=> linear6Code == $past(pwdata[5:0]))
        else $error("linear6 code not taken from write");

    chk_reserved_zero: assert property (
        pready && !pwrite |-> prdata[31:8] == 24'h00_0000 &&
        (isControl(regIndex(paddr)) ? prdata[6:3] == 4'h0 : prdata[7:6] == 2'h0))
        else $error("reserved read bits not zero");

    chk_irq_level: assert property (
        |(faultStatus & stateReg.irqMask) |=> irq)
        else $error("interrupt missing for unmasked status");

    cov_write_done: cover property (writeDone);
    cov_select_flip: cover property (voltageSelect ##1 !voltageSelect);
    cov_irq_raise: cover property (!irq ##1 irq);
    cov_unmapped: cover property (pready && pslverr);
endmodule : regulator_control_registers

// ---- rtl/regulator_control_pkg.sv ----
// Register map, field positions and reset values of the regulator control bank
package regulator_control_pkg;
    // Register indexes; byte address is four times the index
    localparam logic [7:0] BUCK3_PRIMARY_SETPOINT_IDX = 8'h30;
    localparam logic [7:0] BUCK3_SECONDARY_SETPOINT_IDX = 8'h31;
    localparam logic [7:0] BUCK3_CONTROL_IDX = 8'h32;
    localparam logic [7:0] BUCK4_PRIMARY_SETPOINT_IDX = 8'h40;
    localparam logic [7:0] BUCK4_SECONDARY_SETPOINT_IDX = 8'h41;
    localparam logic [7:0] BUCK4_CONTROL_IDX = 8'h42;
    localparam logic [7:0] LINEAR5_SETPOINT_IDX = 8'h50;
    localparam logic [7:0] LINEAR5_CONTROL_IDX = 8'h51;
    localparam logic [7:0] LINEAR6_SETPOINT_IDX = 8'h58;
    localparam logic [7:0] LINEAR6_CONTROL_IDX = 8'h59;
    localparam logic [7:0] FAULT_STATUS_IDX = 8'hE0;
    localparam logic [7:0] FAULT_MASK_IDX = 8'hE1;
    // Control byte field positions
    localparam int ON_BIT = 7;
    localparam int OPTION_BIT = 2;
    localparam int FAULT_EN_BIT = 1;
    localparam int PGOOD_BIT = 0;
    // Regulator numbering inside the bank
    localparam int BUCK3 = 0;
    localparam int BUCK4 = 1;
    localparam int LINEAR5 = 2;
    localparam int LINEAR6 = 3;
    // Values after reset
    localparam logic [5:0] SETPOINT_RESET = 6'h00;
    localparam logic [3:0] FLAGS_RESET = 4'h0;
    localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
endpackage : regulator_control_pkg

// ---- rtl/setpoint_select.sv ----
// Registered choice between primary and secondary voltage code of one buck
module setpoint_select (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic selectHigh,
    input wire logic [5:0] primaryCode,
    input wire logic [5:0] secondaryCode,
    output logic [5:0] codeOut
);
    typedef struct packed {
        logic [5:0] code;
    } sel_state_t;

    sel_state_t stateReg;
    sel_state_t stateNext;

    // Pin high picks the secondary code, low the primary
    always_comb begin
        stateNext = stateReg;
        if (selectHigh) begin
            stateNext.code = secondaryCode;
        end else begin
            stateNext.code = primaryCode;
        end
    end

    // One register stage keeps the output glitch free while the pin moves
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            stateReg <= '{code: regulator_control_pkg::SETPOINT_RESET};
        end else begin
            stateReg <= stateNext;
        end
    end

    assign codeOut = stateReg.code;
endmodule : setpoint_select

// ---- rtl/fault_latch.sv ----
// Sticky fault status bits, set by events and cleared by writing ones
module fault_latch (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [3:0] eventIn,
    input wire logic [3:0] clearBits,
    output logic [3:0] statusOut
);
    typedef struct packed {
        logic [3:0] status;
    } latch_state_t;

    latch_state_t stateReg;
    latch_state_t stateNext;

    // A new event outranks a clear in the same cycle so nothing is lost
    always_comb begin
        stateNext = stateReg;
        stateNext.status = (stateReg.status & ~clearBits) | eventIn;
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            stateReg <= '{status: regulator_control_pkg::FLAGS_RESET};
        end else begin
            stateReg <= stateNext;
        end
    end

    assign statusOut = stateReg.status;
endmodule : fault_latch

// ---- verif/regulator_control_registers_test.sv ----
// Self-checking testbench of the regulator control register bank
module regulator_control_registers_test;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0;
    logic resetN = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] pstrb = 4'hF;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic voltageSelect = 1'b0;
    logic [3:0] powerGood = 4'h0;
    logic [3:0] regulatorFault = 4'h0;
    logic [5:0] buck3Code, buck4Code, linear5Code, linear6Code;
    logic [3:0] regulatorEnable;
    logic [1:0] phaseInvert, dischargeEnable;
    logic irq;
    logic [7:0] rd;
    logic err;
    int mismatches = 0;
    int compares = 0;

    regulator_control_registers i_regulator_control_registers (
        .clk(clk), .reset_n(resetN), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .voltageSelect(voltageSelect), .powerGood(powerGood),
        .regulatorFault(regulatorFault), .buck3Code(buck3Code), .buck4Code(buck4Code),
        .linear5Code(linear5Code), .linear6Code(linear6Code),
        .regulatorEnable(regulatorEnable), .phaseInvert(phaseInvert),
        .dischargeEnable(dischargeEnable), .irq(irq)
    );

    // Free-running 50 MHz clock
    always #10 clk = ~clk;

    task check(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    // One APB transfer; the master waits for pready without assuming a latency
    task apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h000000, wd};
        @(posedge clk);
        penable <= 1'b1;
        // Request stands until pready is seen; only the watchdog ends a hang
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Register outputs lag the stored value, so give them a few edges
    task settle;
        repeat (3) @(posedge clk);
    endtask : settle

    task test_reset;
        logic [7:0] map [12];
        map = '{regulator_control_pkg::BUCK3_PRIMARY_SETPOINT_IDX,
            regulator_control_pkg::BUCK3_SECONDARY_SETPOINT_IDX,
            regulator_control_pkg::BUCK3_CONTROL_IDX,
            regulator_control_pkg::BUCK4_PRIMARY_SETPOINT_IDX,
            regulator_control_pkg::BUCK4_SECONDARY_SETPOINT_IDX,
            regulator_control_pkg::BUCK4_CONTROL_IDX, regulator_control_pkg::LINEAR5_SETPOINT_IDX,
            regulator_control_pkg::LINEAR5_CONTROL_IDX,
            regulator_control_pkg::LINEAR6_SETPOINT_IDX,
            regulator_control_pkg::LINEAR6_CONTROL_IDX, regulator_control_pkg::FAULT_STATUS_IDX,
            regulator_control_pkg::FAULT_MASK_IDX};
        foreach (map[i]) begin
            apb(1'b0, map[i], 8'h00);
            check({rd, 7'h00, err}, 16'h0000, "reset value");
        end
        $display("test reset done");
    endtask : test_reset

    task test_select;
        apb(1'b1, regulator_control_pkg::BUCK3_PRIMARY_SETPOINT_IDX, 8'h15);
        apb(1'b1, regulator_control_pkg::BUCK3_SECONDARY_SETPOINT_IDX, 8'hFA);
        apb(1'b1, regulator_control_pkg::BUCK4_PRIMARY_SETPOINT_IDX, 8'h2C);
        apb(1'b1, regulator_control_pkg::BUCK4_SECONDARY_SETPOINT_IDX, 8'h01);
        settle();
        check({buck3Code, buck4Code}, {6'h15, 6'h2C}, "codes select low");
        @(posedge clk) voltageSelect <= 1'b1;
        settle();
        check({buck3Code, buck4Code}, {6'h3A, 6'h01}, "codes select high");
        @(posedge clk) voltageSelect <= 1'b0;
        settle();
        check(buck3Code, 6'h15, "code back to primary");
        apb(1'b0, regulator_control_pkg::BUCK3_SECONDARY_SETPOINT_IDX, 8'h00);
        check(rd, 8'h3A, "secondary readback");
        $display("test select done");
    endtask : test_select

    task test_linear;
        apb(1'b1, regulator_control_pkg::LINEAR5_SETPOINT_IDX, 8'hFF);
        apb(1'b1, regulator_control_pkg::LINEAR6_SETPOINT_IDX, 8'hA5);
        settle();
        check({linear5Code, linear6Code}, {6'h3F, 6'h25}, "linear codes");
        // Low byte strobe off: the write must be dropped
        pstrb <= 4'hE;
        apb(1'b1, regulator_control_pkg::LINEAR6_SETPOINT_IDX, 8'h11);
        pstrb <= 4'hF;
        settle();
        check(linear6Code, 6'h25, "write without low strobe ignored");
        apb(1'b0, regulator_control_pkg::LINEAR5_SETPOINT_IDX, 8'h00);
        check(rd, 8'h3F, "linear setpoint readback");
        apb(1'b1, regulator_control_pkg::LINEAR5_CONTROL_IDX, 8'h78);
        apb(1'b0, regulator_control_pkg::LINEAR5_CONTROL_IDX, 8'h00);
        check(rd, 8'h00, "control reserved bits");
        $display("test linear done");
    endtask : test_linear

    task test_control;
        @(posedge clk) powerGood <= 4'b0101;
        apb(1'b1, regulator_control_pkg::BUCK3_CONTROL_IDX, 8'hFF);
        apb(1'b1, regulator_control_pkg::BUCK4_CONTROL_IDX, 8'h80);
        apb(1'b1, regulator_control_pkg::LINEAR5_CONTROL_IDX, 8'h84);
        apb(1'b1, regulator_control_pkg::LINEAR6_CONTROL_IDX, 8'h04);
        settle();
        check(regulatorEnable, 4'b0111, "enables on");
        check(phaseInvert, 2'b01, "phase");
        check(dischargeEnable, 2'b10, "discharge only when off");
        apb(1'b0, regulator_control_pkg::BUCK3_CONTROL_IDX, 8'h00);
        check(rd, 8'h87, "buck3 control with good");
        apb(1'b0, regulator_control_pkg::BUCK4_CONTROL_IDX, 8'h00);
        check(rd, 8'h80, "buck4 control not good");
        apb(1'b1, regulator_control_pkg::BUCK3_CONTROL_IDX, 8'h02);
        apb(1'b1, regulator_control_pkg::BUCK4_CONTROL_IDX, 8'h84);
        apb(1'b1, regulator_control_pkg::LINEAR6_CONTROL_IDX, 8'h00);
        settle();
        check(regulatorEnable, 4'b0110, "buck3 off");
        check(phaseInvert, 2'b10, "phase swapped");
        check(dischargeEnable, 2'b00, "discharge disabled");
        $display("test control done");
    endtask : test_control

    // Buck3 has fault interrupts enabled, buck4 and linear5 not, after test_control
    task test_irq;
        apb(1'b1, regulator_control_pkg::FAULT_MASK_IDX, 8'h0F);
        @(posedge clk) regulatorFault <= 4'b0111;
        settle();
        check(irq, 1'b1, "irq on fault");
        @(posedge clk) regulatorFault <= 4'b0000;
        apb(1'b0, regulator_control_pkg::FAULT_STATUS_IDX, 8'h00);
        check(rd, 8'h01, "buck4 fault suppressed");
        apb(1'b1, regulator_control_pkg::FAULT_MASK_IDX, 8'h00);
        settle();
        check(irq, 1'b0, "irq masked");
        apb(1'b1, regulator_control_pkg::FAULT_MASK_IDX, 8'h01);
        settle();
        check(irq, 1'b1, "irq unmasked");
        apb(1'b1, regulator_control_pkg::FAULT_STATUS_IDX, 8'h01);
        settle();
        check(irq, 1'b0, "irq cleared");
        apb(1'b0, regulator_control_pkg::FAULT_STATUS_IDX, 8'h00);
        check(rd, 8'h00, "status cleared");
        $display("test irq done");
    endtask : test_irq

    task test_unmapped;
        apb(1'b1, 8'h33, 8'hAA);
        check(err, 1'b1, "unmapped write error");
        apb(1'b0, 8'h33, 8'h00);
        check({rd, 7'h00, err}, 16'h0001, "unmapped read");
        $display("test unmapped done");
    endtask : test_unmapped

    task summarize;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : summarize

    // Whole run is under two hundred cycles, so this span only trips on a hang
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        $display("[FAIL] %0t watchdog expired", $time);
        summarize();
    end

    initial begin
        repeat (10) @(posedge clk);
        resetN <= 1'b1;
        test_reset();
        test_select();
        test_linear();
        test_control();
        test_irq();
        test_unmapped();
        summarize();
    end
endmodule : regulator_control_registers_test
